/* File: mif_top.sv */
// Top of the metering interrupt flags: APB register file, sticky flags and interrupt pin.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module mif_top (
  // Clock, reset and clock enable.
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Measurement inputs from the metering datapath, same clock.
  input wire logic act_ovf_evt_in,
  input wire logic smp_valid_in,
  input wire logic [mif_pkg::MIF_SMP_W-1:0] v_smp_in,
  input wire logic [mif_pkg::MIF_SMP_W-1:0] i_smp_in,
  input wire logic [mif_pkg::MIF_ACC_W-1:0] apparent_energy_accumulator_in,
  input wire logic zx_pulse_in,
  input wire logic cycle_pulse_in,
  input wire logic power_valid_in,
  input wire logic power_neg_in,
  // Open-drain interrupt request pin: output level and enable (low enable drives).
  output logic irq_n_out,
  output logic irq_oe_n_out
);
  import mif_pkg::*;

  // Event pulses from the detector.
  mif_evt_if evt_bus();

  logic [15:0] flags_r, flags_nxt; // Sticky status flags.
  logic [15:0] enable_r, enable_nxt; // Interrupt enable mask.
  logic [23:0] vpk_r, vpk_nxt; // Voltage peak level.
  logic [23:0] ipk_r, ipk_nxt; // Current peak level.
  logic [11:0] zxc_r, zxc_nxt; // Zero crossing timeout in line cycles.
  logic [31:0] prdata_r, prdata_nxt; // Read data register.
  logic pready_r, pready_nxt; // Ready register.
  logic pslverr_r, pslverr_nxt; // Error register.
  logic irq_r, irq_nxt; // Interrupt asserted (active high internally).
  logic [1:0] sign_state; // Detector sign state.
  logic acc_take; // Access phase completing this cycle.
  logic acc_rd; // Completing read.
  logic acc_wr; // Completing write.

  // Decode whether an address maps to a register.
  function automatic logic mif_mapped(input logic [7:0] a);
    mif_mapped = (a == {MIF_IDX_ENABLE[5:0], 2'b00}) || (a == {MIF_IDX_STATUS[5:0], 2'b00}) ||
                 (a == {MIF_IDX_RSTATUS[5:0], 2'b00}) || (a == {MIF_IDX_PEAKV[5:0], 2'b00}) ||
                 (a == {MIF_IDX_PEAKI[5:0], 2'b00}) || (a == {MIF_IDX_ZXCFG[5:0], 2'b00}) ||
                 (a == {MIF_IDX_SIGN[5:0], 2'b00});
  endfunction

  // Byte address of a register index.
  function automatic logic [7:0] mif_addr(input logic [7:0] idx);
    mif_addr = {idx[5:0], 2'b00};
  endfunction

  // Event detector.
  mif_event_detect u_detect (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .act_ovf_evt_in(act_ovf_evt_in),
    .smp_valid_in(smp_valid_in),
    .v_smp_in(v_smp_in),
    .i_smp_in(i_smp_in),
    .apparent_energy_accumulator_in(apparent_energy_accumulator_in),
    .zx_pulse_in(zx_pulse_in),
    .cycle_pulse_in(cycle_pulse_in),
    .power_valid_in(power_valid_in),
    .power_neg_in(power_neg_in),
    .voltage_peak_level_in(vpk_r),
    .current_peak_level_in(ipk_r),
    .zx_cycles_in(zxc_r),
    .ev(evt_bus.src),
    .sign_state_out(sign_state)
  );

  // The slave answers in the second access cycle: pready is registered and high once.
  assign acc_take = psel_in && penable_in && !pready_r;
  assign acc_rd = acc_take && !pwrite_in;
  assign acc_wr = acc_take && pwrite_in;

  // Next values of the register file, flags and bus answer.
  always_comb begin
    flags_nxt = flags_r;
    enable_nxt = enable_r;
    vpk_nxt = vpk_r;
    ipk_nxt = ipk_r;
    zxc_nxt = zxc_r;
    prdata_nxt = prdata_r;
    pready_nxt = acc_take;
    pslverr_nxt = 1'b0;
    // Clear phase: reading the reset-status register or writing ones to status.
    if (acc_rd && paddr_in == mif_addr(MIF_IDX_RSTATUS)) begin
      flags_nxt = MIF_RST_FLAGS;
    end
    if (acc_wr && paddr_in == mif_addr(MIF_IDX_STATUS)) begin
      // Write-one-to-clear of status bits.
      flags_nxt = flags_nxt & ~(pwdata_in[15:0] & MIF_FLAG_MASK);
    end
    // Events set flags, winning over clears.
    flags_nxt = (flags_nxt | evt_bus.evt) & MIF_FLAG_MASK;
    // Register writes.
    if (acc_wr) begin
      if (paddr_in == mif_addr(MIF_IDX_ENABLE)) begin
        enable_nxt = pwdata_in[15:0] & MIF_FLAG_MASK;
      end else if (paddr_in == mif_addr(MIF_IDX_PEAKV)) begin
        vpk_nxt = pwdata_in[23:0];
      end else if (paddr_in == mif_addr(MIF_IDX_PEAKI)) begin
        ipk_nxt = pwdata_in[23:0];
      end else if (paddr_in == mif_addr(MIF_IDX_ZXCFG)) begin
        zxc_nxt = pwdata_in[11:0];
      end
    end
    // Read data mux; unmapped addresses read zero and flag an error.
    if (acc_take) begin
      prdata_nxt = 32'h00000000;
      if (!mif_mapped(paddr_in)) begin
        pslverr_nxt = 1'b1;
      end else if (!pwrite_in) begin
        if (paddr_in == mif_addr(MIF_IDX_ENABLE)) begin
          prdata_nxt = {16'h0000, enable_r};
        end else if (paddr_in == mif_addr(MIF_IDX_STATUS) ||
                     paddr_in == mif_addr(MIF_IDX_RSTATUS)) begin
          prdata_nxt = {16'h0000, flags_r & MIF_FLAG_MASK};
        end else if (paddr_in == mif_addr(MIF_IDX_PEAKV)) begin
          prdata_nxt = {8'h00, vpk_r};
        end else if (paddr_in == mif_addr(MIF_IDX_PEAKI)) begin
          prdata_nxt = {8'h00, ipk_r};
        end else if (paddr_in == mif_addr(MIF_IDX_ZXCFG)) begin
          prdata_nxt = {20'h00000, zxc_r};
        end else begin
          prdata_nxt = {30'h0, sign_state};
        end
      end
    end
    irq_nxt = |(flags_nxt & enable_nxt);
  end

  // Register stage for all state of the top.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      flags_r <= MIF_RST_FLAGS;
      enable_r <= MIF_RST_ENABLE;
      vpk_r <= MIF_RST_PEAK;
      ipk_r <= MIF_RST_PEAK;
      zxc_r <= MIF_RST_ZXCYC;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce_in) begin
      flags_r <= flags_nxt;
      enable_r <= enable_nxt;
      vpk_r <= vpk_nxt;
      ipk_r <= ipk_nxt;
      zxc_r <= zxc_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Outputs straight from flip-flops, pin level tied low; open drain pulls low by enabling the driver.
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign irq_n_out = 1'b0;
  assign irq_oe_n_out = ~irq_r;
endmodule

/* File: mif_pkg.sv */
// Package with register map, field positions and reset values for the metering interrupt flags.
package mif_pkg;
  // Register indexes; the APB byte address of each register is four times its index.
  localparam logic [7:0] MIF_IDX_ENABLE = 8'h0A;
  localparam logic [7:0] MIF_IDX_STATUS = 8'h0B;
  localparam logic [7:0] MIF_IDX_RSTATUS = 8'h0C;
  localparam logic [7:0] MIF_IDX_PEAKV = 8'h10;
  localparam logic [7:0] MIF_IDX_PEAKI = 8'h11;
  localparam logic [7:0] MIF_IDX_ZXCFG = 8'h12;
  localparam logic [7:0] MIF_IDX_SIGN = 8'h13;
  // Field positions inside the status and enable registers.
  localparam int MIF_BIT_ACT_OVF_POS = 7;
  localparam int MIF_BIT_VPK_POS = 8;
  localparam int MIF_BIT_IPK_POS = 9;
  localparam int MIF_BIT_VAHF_POS = 10;
  localparam int MIF_BIT_VAOF_POS = 11;
  localparam int MIF_BIT_ZX_TMO_POS = 12;
  localparam int MIF_BIT_PWR_UP_POS = 13;
  localparam int MIF_BIT_PWR_DN_POS = 14;
  // Writable and readable bits of the flag registers, bits 7 to 14.
  localparam logic [15:0] MIF_FLAG_MASK = 16'h7F80;
  // Reset values.
  localparam logic [15:0] MIF_RST_FLAGS = 16'h0000;
  localparam logic [15:0] MIF_RST_ENABLE = 16'h0000;
  localparam logic [23:0] MIF_RST_PEAK = 24'hFFFFFF;
  localparam logic [11:0] MIF_RST_ZXCYC = 12'hFFF;
  // Width of the apparent energy accumulator and of waveform samples.
  localparam int MIF_ACC_W = 24;
  localparam int MIF_SMP_W = 24;
  // Sign tracker states.
  typedef enum logic [1:0] {MIF_SGN_UNKNOWN, MIF_SGN_POS, MIF_SGN_NEG} mif_sign_e;
endpackage

/* File: mif_evt_if.sv */
// Interface carrying event pulses from the event detector to the flag register.
`timescale 1ns/1ps
interface mif_evt_if;
  // One-cycle event pulses, one bit per flag position.
  logic [15:0] evt;
  modport src (output evt);
  modport dst (input evt);
endinterface

/* File: mif_event_detect.sv */
// Event detector: peak crossings, half-full and overflow of apparent energy, zero-cross timeout, sign.
`timescale 1ns/1ps
module mif_event_detect (
  // Clock, reset and enable.
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Measurement inputs on the same clock.
  input wire logic act_ovf_evt_in,
  input wire logic smp_valid_in,
  input wire logic [23:0] v_smp_in,
  input wire logic [23:0] i_smp_in,
  input wire logic [23:0] apparent_energy_accumulator_in,
  input wire logic zx_pulse_in,
  input wire logic cycle_pulse_in,
  input wire logic power_valid_in,
  input wire logic power_neg_in,
  // Configuration from the register file.
  input wire logic [23:0] voltage_peak_level_in,
  input wire logic [23:0] current_peak_level_in,
  input wire logic [11:0] zx_cycles_in,
  // Event pulses towards the flag register.
  mif_evt_if.src ev,
  // Current sign state for readback.
  output logic [1:0] sign_state_out
);
  import mif_pkg::*;

  // Magnitude of a two's complement sample.
  function automatic logic [23:0] mif_abs(input logic [23:0] s);
    mif_abs = s[23] ? 24'(-s) : s;
  endfunction

  logic acc_msb_r, acc_msb_nxt; // Previous top bit of the accumulator.
  logic [11:0] zx_cnt_r, zx_cnt_nxt; // Line cycles since last zero crossing.
  logic zx_armed_r, zx_armed_nxt; // Timeout fires once per silence.
  mif_sign_e sgn_r, sgn_nxt; // Last known power sign.
  logic [15:0] evt_r, evt_nxt; // Registered event pulses.

  // Next-state logic of all detectors.
  always_comb begin
    evt_nxt = 16'h0000;
    acc_msb_nxt = apparent_energy_accumulator_in[MIF_ACC_W-1];
    zx_cnt_nxt = zx_cnt_r;
    zx_armed_nxt = zx_armed_r;
    sgn_nxt = sgn_r;
    evt_nxt[MIF_BIT_ACT_OVF_POS] = act_ovf_evt_in;
    evt_nxt[MIF_BIT_VPK_POS] = smp_valid_in && (mif_abs(v_smp_in) > voltage_peak_level_in);
    evt_nxt[MIF_BIT_IPK_POS] = smp_valid_in && (mif_abs(i_smp_in) > current_peak_level_in);
    evt_nxt[MIF_BIT_VAHF_POS] = !acc_msb_r && apparent_energy_accumulator_in[MIF_ACC_W-1];
    evt_nxt[MIF_BIT_VAOF_POS] = acc_msb_r && !apparent_energy_accumulator_in[MIF_ACC_W-1];
    if (zx_pulse_in) begin
      zx_cnt_nxt = 12'h000;
      zx_armed_nxt = 1'b1;
    end else if (cycle_pulse_in && zx_armed_r) begin
      if (zx_cnt_r + 12'h001 >= zx_cycles_in) begin
        evt_nxt[MIF_BIT_ZX_TMO_POS] = 1'b1;
        zx_armed_nxt = 1'b0;
        zx_cnt_nxt = 12'h000;
      end else begin
        zx_cnt_nxt = zx_cnt_r + 12'h001;
      end
    end
    // Sign change detection on each valid power value.
    if (power_valid_in) begin
      case (sgn_r)
        MIF_SGN_POS: begin
          if (power_neg_in) begin
            evt_nxt[MIF_BIT_PWR_DN_POS] = 1'b1;
          end
        end
        MIF_SGN_NEG: begin
          if (!power_neg_in) begin
            evt_nxt[MIF_BIT_PWR_UP_POS] = 1'b1;
          end
        end
        default: begin
        end
      endcase
      sgn_nxt = power_neg_in ? MIF_SGN_NEG : MIF_SGN_POS;
    end
  end

  // Register the detector state.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      acc_msb_r <= 1'b0;
      zx_cnt_r <= 12'h000;
      zx_armed_r <= 1'b1;
      sgn_r <= MIF_SGN_UNKNOWN;
      evt_r <= 16'h0000;
    end else if (ce_in) begin
      acc_msb_r <= acc_msb_nxt;
      zx_cnt_r <= zx_cnt_nxt;
      zx_armed_r <= zx_armed_nxt;
      sgn_r <= sgn_nxt;
      evt_r <= evt_nxt;
    end
  end

  assign ev.evt = evt_r;
  assign sign_state_out = sgn_r;
endmodule

/* File: mif_host_model.sv */
// Host side of the interrupt request pin with its pull-up resistor.
`timescale 1ns/1ps
module mif_host_model (
  // Open-drain pin as driven by the device.
  input wire logic irq_n_in,
  input wire logic irq_oe_n_in,
  // Resolved wire level seen by the host.
  output logic irq_line_out
);
  // pull-up resolve: a released pin floats high, a driven one follows the device.
  assign irq_line_out = irq_oe_n_in ? 1'b1 : irq_n_in;
endmodule

/* File: mif_top_props.sv */
// Checker with the port-level properties of the interrupt flag block.
`timescale 1ns/1ps
module mif_top_props (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Bus.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Interrupt pin.
  input wire logic irq_n_out,
  input wire logic irq_oe_n_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  // True for the byte addresses that hold a register.
  function automatic logic mapped(input logic [7:0] a);
    return a inside {8'h28, 8'h2C, 8'h30, 8'h40, 8'h44, 8'h48, 8'h4C};
  endfunction
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  ready_time_a: assert property (
    psel_in && !penable_in && ce_in |=> !pready_out ##1 pready_out)
    else $error("ready not two cycles after setup");
  unmapped_err_a: assert property (
    psel_in && !penable_in && ce_in && !mapped(paddr_in) |-> ##2 pslverr_out)
    else $error("no error for unmapped address");
  mapped_ok_a: assert property (
    psel_in && !penable_in && ce_in && mapped(paddr_in) |-> ##2 !pslverr_out)
    else $error("error for a mapped address");
  err_data_a: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error answer carries data");
  upper_zero_a: assert property (pready_out |-> prdata_out[31:24] == 8'h00)
    else $error("upper read bits not zero");
  irq_release_a: assert property ($rose(irq_oe_n_out) |->
    $past(psel_in && penable_in) || $past(psel_in && penable_in, 2))
    else $error("interrupt released without a bus access");
  pin_low_a: assert property (!irq_oe_n_out |-> !irq_n_out)
    else $error("interrupt pin driven high");
endmodule
bind mif_top mif_top_props u_props (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_n_out(irq_n_out),
  .irq_oe_n_out(irq_oe_n_out));

/* File: test_metering_interrupt_flags.sv */
// Self-checking testbench for the metering interrupt flags over APB.
`timescale 1ns/1ps
module test_metering_interrupt_flags;
  import mif_pkg::*;
  // Byte addresses, four times the register index.
  localparam logic [7:0] A_EN = {MIF_IDX_ENABLE[5:0], 2'b00};
  localparam logic [7:0] A_ST = {MIF_IDX_STATUS[5:0], 2'b00};
  localparam logic [7:0] A_RS = {MIF_IDX_RSTATUS[5:0], 2'b00};
  localparam logic [7:0] A_PV = {MIF_IDX_PEAKV[5:0], 2'b00};
  localparam logic [7:0] A_PI = {MIF_IDX_PEAKI[5:0], 2'b00};
  localparam logic [7:0] A_ZX = {MIF_IDX_ZXCFG[5:0], 2'b00};
  localparam logic [7:0] A_SG = {MIF_IDX_SIGN[5:0], 2'b00};
  // Design inputs, all given a value at time zero.
  logic clk = 0, srst = 1, ce = 1, psel = 0, pen = 0, pwr = 0, aovf = 0, sv = 0, zx = 0;
  logic cyc = 0, pv = 0, power_went_negative_flag = 0, err, perr, irq_n, irq_oe_n, irq_line, rdy;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h00000000, prd, d;
  logic [23:0] v = 24'h000000, i = 24'h000000, acc = 24'h000000;
  int num_errors = 0, n_compared = 0, cycles = 0;
  always #10 clk = ~clk;
  mif_top i_dut (.clk_sys_in(clk), .srst_in(srst), .ce_in(ce), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(err), .act_ovf_evt_in(aovf), .smp_valid_in(sv),
    .v_smp_in(v), .i_smp_in(i), .apparent_energy_accumulator_in(acc), .zx_pulse_in(zx),
    .cycle_pulse_in(cyc), .power_valid_in(pv), .power_neg_in(power_went_negative_flag), .irq_n_out(irq_n),
    .irq_oe_n_out(irq_oe_n));
  mif_host_model i_host (.irq_n_in(irq_n), .irq_oe_n_in(irq_oe_n), .irq_line_out(irq_line));
  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  // Compares one value and reports a difference.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; waits as long as ready takes, then idles one cycle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= wd;
    @(posedge clk) pen <= 1;
    @(posedge clk);
    while (rdy !== 1'b1) begin
      @(posedge clk);
    end
    // The error answer stands only in the ready cycle; read data holds until the next access.
    r = prd;
    perr = err;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0, d);
    chk(nm, d, e);
  endtask
  // Raises one kind of event, then lets the flag settle.
  task automatic fire(input int k);
    case (k)
      0: aovf <= 1;
      1: begin v <= 24'h000065; sv <= 1; end
      2: begin i <= 24'hFFFF9B; sv <= 1; end
      3: acc <= 24'h800000;
      4: acc <= 24'h000000;
      5: begin
        repeat (3) begin
          cyc <= 1; @(posedge clk) cyc <= 0; @(posedge clk);
        end
      end
      6: begin pv <= 1; power_went_negative_flag <= 1; @(posedge clk) pv <= 0; @(posedge clk) pv <= 1; power_went_negative_flag <= 0; end
      default: begin pv <= 1; power_went_negative_flag <= 1; end
    endcase
    @(posedge clk) begin aovf <= 0; sv <= 0; pv <= 0; v <= 24'h0; i <= 24'h0; end
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    rchk("enable", A_EN, 32'h0);
    rchk("peak level", A_PV, 32'h00FFFFFF);
    rchk("zx cycles", A_ZX, 32'h00000FFF);
    apb(0, 8'h04, 32'h0, d);
    chk("unmapped err", {31'h0, perr}, 32'h1);
    chk("unmapped data", d, 32'h0);
    apb(1, A_EN, 32'hFFFFFFFF, d);
    rchk("enable", A_EN, 32'h00007F80);
    apb(1, A_PV, 32'h64, d);
    apb(1, A_PI, 32'h64, d);
    apb(1, A_ZX, 32'h3, d);
    rchk("peak i", A_PI, 32'h00000064);
    // A sample equal to the level must not count as a crossing.
    sv <= 1; v <= 24'h000064; i <= 24'hFFFF9C;
    @(posedge clk) sv <= 0;
    repeat (3) @(posedge clk);
    rchk("status", A_ST, 32'h0);
    for (int k = 0; k < 8; k++) begin
      fire(k);
      // Host reads the status first when servicing.
      rchk("status", A_ST, 32'h1 << (7 + k));
      chk("irq", {31'h0, irq_line}, 32'h0);
      apb(1, A_ST, 32'h1 << (7 + k), d);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, irq_line}, 32'h1);
    end
    rchk("sign", A_SG, 32'h2);
    apb(1, A_EN, 32'h0, d);
    fire(0);
    chk("irq masked", {31'h0, irq_line}, 32'h1);
    apb(1, A_EN, 32'h80, d);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq_line}, 32'h0);
    rchk("rstatus", A_RS, 32'h80);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq_line}, 32'h1);
    rchk("status", A_ST, 32'h0);
    // With the clock enable low an event pulse must be lost and the pin must stay released.
    ce <= 0;
    aovf <= 1;
    @(posedge clk) aovf <= 0;
    repeat (3) @(posedge clk);
    chk("irq frozen", {31'h0, irq_line}, 32'h1);
    ce <= 1;
    @(posedge clk);
    rchk("status frozen", A_ST, 32'h0);
    // The timeout has fired once, so more silent line cycles must not set it again.
    fire(5);
    rchk("status", A_ST, 32'h0);
    // A zero crossing rearms the timeout.
    zx <= 1;
    @(posedge clk) zx <= 0;
    fire(5);
    rchk("status", A_ST, 32'h00001000);
    tally_and_finish;
  end
endmodule
